// ### verilog/pcc_top.sv
`timescale 1ns/10ps
`include "pcc_params.svh"
module pcc_top #(
  parameter int HOLD = `PCC_RST_HOLD_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        button_rst_n,
  input  wire logic        board_rst_n,
  input  wire logic [2:0]  lower_fitted,
  input  wire logic        clock_test_output,
  output logic             high_vector_select,
  output logic             big_endian_init,
  output logic             dft_enable_input,
  output logic      [3:0]  clock_test_select,
  output logic             cpu_rst_n,
  output logic      [1:0]  proc_id,
  output logic      [3:0]  mem_base_nib,
  output logic             misc_led
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [5:0]       init_q;
  logic             led_q;
  logic             soft_req_q;
  logic             btn_s;
  logic             brd_s;
  logic             btn_d_q;
  logic             brd_d_q;
  logic             man_req;
  logic [2:0]       fit_s;
  logic             ctout_s;
  pcc_pkg::pcc_id_t id_q;
  logic             hold_rst_n;
  logic             busy;
  logic             setup;
  logic             wr_en;
  logic             hit;
  logic [31:0]      rd_d;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Count contiguous fitted modules below, from the lowest
  function automatic pcc_pkg::pcc_id_t stack_id(input logic [2:0] f);
    pcc_pkg::pcc_id_t r;
    r = 2'h0;
    if (f[0]) begin
      r = 2'h1;
      if (f[1]) begin
        r = 2'h2;
        if (f[2]) begin
          r = 2'h3;
        end
      end
    end
    return r;
  endfunction

  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pcc_sync #(
    .W (1)
  ) u_sync_btn (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (~button_rst_n),
    .q       (btn_s)
  );

  pcc_sync #(
    .W (1)
  ) u_sync_brd (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (~board_rst_n),
    .q       (brd_s)
  );

  pcc_sync #(
    .W (3)
  ) u_sync_fit (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (lower_fitted),
    .q       (fit_s)
  );

  pcc_sync #(
    .W (1)
  ) u_sync_ct (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (clock_test_output),
    .q       (ctout_s)
  );

  // ----------------------------------------------------------------
  // Manual reset request
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_d_q <= 1'b0;
      brd_d_q <= 1'b0;
    end else begin
      btn_d_q <= btn_s;
      brd_d_q <= brd_s;
    end
  end

  // Button, board and software requests all start the same hold
  assign man_req = (btn_s && !btn_d_q) || (brd_s && !brd_d_q) ||
                   soft_req_q;

  pcc_rst_seq #(
    .HOLD (HOLD)
  ) u_rst_seq (
    .pclk      (pclk),
    .presetn   (presetn),
    .req       (man_req),
    .cpu_rst_n (hold_rst_n),
    .busy      (busy)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_rst_n <= 1'b0;
    end else begin
      cpu_rst_n <= hold_rst_n;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    hit  = 1'b1;
    rd_d = 32'h0000_0000;
    if (addr_is(paddr, `PCC_OFF_CTRL)) begin
      rd_d[`PCC_CTRL_LED] = led_q;
    end else if (addr_is(paddr, `PCC_OFF_STAT)) begin
      rd_d[`PCC_STAT_ID_HI:`PCC_STAT_ID_LO] = id_q;
      rd_d[`PCC_STAT_CTOUT] = ctout_s;
      rd_d[`PCC_STAT_BUSY]  = busy;
    end else if (addr_is(paddr, `PCC_OFF_INIT)) begin
      rd_d[5:0] = init_q;
    end else begin
      hit = 1'b0;
    end
  end

  // Answer in the first access cycle; data captured in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit;
      if (setup && !pwrite) begin
        prdata <= rd_d;
      end else if (setup) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_q      <= 1'b0;
      soft_req_q <= 1'b0;
    end else begin
      soft_req_q <= 1'b0;
      if (wr_en && addr_is(paddr, `PCC_OFF_CTRL)) begin
        led_q      <= pwdata[`PCC_CTRL_LED];
        soft_req_q <= pwdata[`PCC_CTRL_RESET];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_led <= 1'b0;
    end else begin
      misc_led <= led_q;
    end
  end

  // ----------------------------------------------------------------
  // Init register
  // ----------------------------------------------------------------
  // Cleared only by power-on reset, never by a manual reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q <= `PCC_INIT_RST;
    end else if (wr_en && addr_is(paddr, `PCC_OFF_INIT)) begin
      init_q <= pwdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Processor configuration pins
  // ----------------------------------------------------------------
  // Pins follow the register only while the processor is in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_vector_select <= 1'b0;
      big_endian_init    <= 1'b0;
      clock_test_select  <= `PCC_CT_NORMAL;
    end else if (!hold_rst_n) begin
      high_vector_select <= init_q[`PCC_INIT_HIVEC];
      big_endian_init    <= init_q[`PCC_INIT_BIGEND];
      clock_test_select  <= init_q[`PCC_INIT_CT_HI:`PCC_INIT_CT_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dft_enable_input <= 1'b0;
    end else begin
      dft_enable_input <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Module identity
  // ----------------------------------------------------------------
  // Position caught during the processor reset hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_q <= 2'h0;
    end else if (!hold_rst_n) begin
      id_q <= stack_id(fit_s);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proc_id      <= 2'h0;
      mem_base_nib <= `PCC_MEM_BASE_NIB;
    end else begin
      proc_id      <= id_q;
      mem_base_nib <= `PCC_MEM_BASE_NIB + {2'h0, id_q};
    end
  end
endmodule

// ### verilog/pcc_params.svh
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PCC_OFF_CTRL      12'h000
`define PCC_OFF_STAT      12'h004
`define PCC_OFF_INIT      12'h008

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCC_CTRL_LED      0
`define PCC_CTRL_RESET    3
`define PCC_INIT_HIVEC    0
`define PCC_INIT_BIGEND   1
`define PCC_INIT_CT_LO    2
`define PCC_INIT_CT_HI    5
`define PCC_STAT_ID_LO    0
`define PCC_STAT_ID_HI    1
`define PCC_STAT_CTOUT    2
`define PCC_STAT_BUSY     3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PCC_INIT_RST      6'h00
`define PCC_CT_NORMAL     4'h0
`define PCC_MEM_BASE_NIB  4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PCC_CLK_MHZ       25
`define PCC_RST_HOLD_NS   1000
`define PCC_RST_HOLD_CYC  ((`PCC_RST_HOLD_NS * `PCC_CLK_MHZ + 999) / 1000)
`endif

// ### verilog/pcc_pkg.sv
package pcc_pkg;
  typedef enum logic [2:0] {
    PCC_RUN  = 3'b001,
    PCC_HOLD = 3'b010,
    PCC_REL  = 3'b100
  } pcc_rst_e;
  typedef logic [1:0] pcc_id_t;
endpackage

// ### verilog/pcc_sync.sv
`timescale 1ns/10ps
module pcc_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ### verilog/pcc_rst_seq.sv
`timescale 1ns/10ps
`include "pcc_params.svh"
module pcc_rst_seq #(
  parameter int HOLD = `PCC_RST_HOLD_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic req,
  output logic      cpu_rst_n,
  output logic      busy
);
  localparam int CW = $clog2(HOLD + 1);

  pcc_pkg::pcc_rst_e state_q;
  logic [CW-1:0]     cnt_q;

  // ----------------------------------------------------------------
  // Hold sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pcc_pkg::PCC_HOLD;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        pcc_pkg::PCC_RUN: begin
          cnt_q <= '0;
          if (req) begin
            state_q <= pcc_pkg::PCC_HOLD;
          end
        end
        pcc_pkg::PCC_HOLD: begin
          // Restart the hold on a fresh request
          if (req) begin
            cnt_q <= '0;
          end else if (cnt_q == CW'(HOLD - 1)) begin
            state_q <= pcc_pkg::PCC_REL;
          end else begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
        pcc_pkg::PCC_REL: begin
          state_q <= pcc_pkg::PCC_RUN;
        end
        default: begin
          state_q <= pcc_pkg::PCC_HOLD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_rst_n <= 1'b0;
      busy      <= 1'b1;
    end else begin
      cpu_rst_n <= (state_q == pcc_pkg::PCC_REL) ||
                   (state_q == pcc_pkg::PCC_RUN && !req);
      busy      <= (state_q != pcc_pkg::PCC_RUN) || req;
    end
  end
endmodule

// ### testbench/pcc_monitor.sv
`timescale 1ns/10ps
`include "pcc_params.svh"
module pcc_monitor #(
  parameter int HOLD = 4
) (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  input logic        high_vector_select,
  input logic        big_endian_init,
  input logic        dft_enable_input,
  input logic [3:0]  clock_test_select,
  input logic        cpu_rst_n,
  input logic [1:0]  proc_id,
  input logic [3:0]  mem_base_nib
);
  logic [15:0] low_q;
  logic        sw_wr;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign sw_wr = psel && penable && pready && pwrite
                 && paddr == `PCC_OFF_CTRL && pwdata[`PCC_CTRL_RESET];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_q <= 16'h0000;
    else if (!cpu_rst_n) low_q <= low_q + 16'h0001;
    else low_q <= 16'h0000;
  end
  dft_low_a: assert property (!dft_enable_input)
    else $error("test enable pin not low");
  cfg_hold_a: assert property (cpu_rst_n && $past(cpu_rst_n) |->
    $stable({high_vector_select, big_endian_init, clock_test_select})
    && $stable(proc_id)) else $error("config pins moved outside reset");
  por_dflt_a: assert property ($rose(presetn) |->
    !high_vector_select && !big_endian_init
    && clock_test_select == `PCC_CT_NORMAL) else $error("bad defaults");
  sw_rst_a: assert property (sw_wr |-> ##[1:4] !cpu_rst_n)
    else $error("software reset not applied");
  hold_len_a: assert property (cpu_rst_n && !$past(cpu_rst_n) |->
    low_q >= HOLD) else $error("processor reset too short");
  mem_base_a: assert property (
    mem_base_nib == `PCC_MEM_BASE_NIB + {2'h0, proc_id})
    else $error("memory base does not follow id");
  pready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one access cycle");
  err_rdy_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  sw_c: cover property (sw_wr);
  err_c: cover property (pslverr);
  rel_c: cover property ($rose(cpu_rst_n));
endmodule
bind pcc_top pcc_monitor #(.HOLD(HOLD)) u_mon (.*);

// ### testbench/pcc_cpu_model.sv
`timescale 1ns/10ps
module pcc_cpu_model (
  input  logic       pclk,
  input  logic       cpu_rst_n,
  input  logic       high_vector_select,
  input  logic       big_endian_init,
  input  logic [3:0] clock_test_select,
  output logic       clock_test_output = 1'b0,
  output logic       hv_q,
  output logic       be_q,
  output logic [3:0] cts_q
);
  always_ff @(posedge cpu_rst_n) begin
    hv_q <= high_vector_select;
    be_q <= big_endian_init;
    cts_q <= clock_test_select;
  end
  always_ff @(posedge pclk) begin
    if (clock_test_select == 4'h0) clock_test_output <= 1'b0;
    else clock_test_output <= ~clock_test_output;
  end
endmodule

// ### testbench/tb_processor_config_control.sv
`timescale 1ns/10ps
`include "pcc_params.svh"
`define CHK(n, e, g) begin num_checks++; if ((e) !== (g)) begin \
  n_fail++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_processor_config_control;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        button_rst_n, board_rst_n, clock_test_output, misc_led;
  logic [2:0]  lower_fitted;
  logic        high_vector_select, big_endian_init, dft_enable_input;
  logic [3:0]  clock_test_select, mem_base_nib, cts_q;
  logic        cpu_rst_n, hv_q, be_q;
  logic [1:0]  proc_id;
  logic [32:0] exp_q[$];
  logic [32:0] r;
  logic [7:0]  seed = 8'h11;
  logic [5:0]  ini, cur;
  int          n_fail = 0;
  int          num_checks = 0;
  always #20 pclk = ~pclk;
  pcc_top #(.HOLD(4)) u_dut (.*);
  pcc_cpu_model u_cpu (.*);
  task summarize;
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [32:0] e);
    if (!w) exp_q.push_back(e);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rst_wait;
    while (cpu_rst_n !== 1'b0) @(posedge pclk);
    while (cpu_rst_n !== 1'b1) @(posedge pclk);
    @(posedge pclk);
  endtask
  task pins(input logic [5:0] v);
    `CHK("hv", v[0], high_vector_select)
    `CHK("be", v[1], big_endian_init)
    `CHK("cts", v[5:2], clock_test_select)
    `CHK("seen", {v[0], v[1], v[5:2]}, {hv_q, be_q, cts_q})
    `CHK("dft", 1'b0, dft_enable_input)
  endtask
  function logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      r = exp_q.pop_front();
      `CHK("read", r, {pslverr, prdata})
    end
  end
  initial begin
    presetn <= 1'b0; psel <= 1'b0; penable <= 1'b0; pwrite <= 1'b0;
    paddr <= 12'h000; pwdata <= 32'h0; lower_fitted <= 3'h3;
    button_rst_n <= 1'b1; board_rst_n <= 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rst_wait;
    pins(6'h00);
    xfer(1'b0, `PCC_OFF_STAT, 32'h0, 33'h2);
    `CHK("id", 2'h2, proc_id)
    `CHK("base", 4'ha, mem_base_nib)
    xfer(1'b0, `PCC_OFF_INIT, 32'h0, 33'h0);
    xfer(1'b0, 12'h00c, 32'h0, {1'b1, 32'h0});
    lower_fitted <= 3'h5;
    cur = 6'h00;
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      ini = seed[5:0] ^ 6'h2a;
      xfer(1'b1, `PCC_OFF_INIT, {26'h0, ini}, 33'h0);
      pins(cur);
      case (k)
        0: xfer(1'b1, `PCC_OFF_CTRL, 32'h9, 33'h0);
        1: button_rst_n <= 1'b0;
        default: board_rst_n <= 1'b0;
      endcase
      repeat (2) @(posedge pclk);
      button_rst_n <= 1'b1; board_rst_n <= 1'b1;
      rst_wait;
      pins(ini);
      xfer(1'b0, `PCC_OFF_INIT, 32'h0, {27'h0, ini});
      cur = ini;
    end
    `CHK("id", 2'h1, proc_id)
    `CHK("base", 4'h9, mem_base_nib)
    `CHK("led", 1'b1, misc_led)
    xfer(1'b0, `PCC_OFF_CTRL, 32'h0, 33'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rst_wait;
    pins(6'h00);
    xfer(1'b0, `PCC_OFF_INIT, 32'h0, 33'h0);
    summarize;
  end
  initial begin
    repeat (4000) @(posedge pclk);
    n_fail++;
    summarize;
  end
endmodule
